// file: verilog/gts_pkg.sv
// package: register map, field layout and output-select codes of the pin block
package gts_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_SLOTS = 12;
  localparam int unsigned NUM_PINS = 2;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W = 7;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] OFS_OUTPUT_SELECT = 16'h0023;
  localparam logic [15:0] OFS_INPUT_LEVELS = 16'h0025;
  localparam logic [15:0] OFS_EXTENSION = 16'h0026;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned POS_PIN0_SEL = 0;
  localparam int unsigned POS_PIN1_SEL = 8;
  localparam int unsigned POS_IDLE_LEVEL = 8;
  localparam int unsigned POS_EDGE_INV = 7;
  localparam int unsigned POS_KEEP_ARMED = 6;
  localparam int unsigned POS_PIN_SELECT = 4;
  localparam logic [6:0] RST_SELECT = 7'h00;
  localparam logic [1:0] RST_PIN_SELECT = 2'h0;
  localparam logic [1:0] STAMP_PIN0 = 2'h0;
  localparam logic [1:0] STAMP_PIN1 = 2'h1;

  // ----------------------------------------------------------------------
  // output-select codes
  // ----------------------------------------------------------------------
  localparam logic [6:0] SEL_LOW = 7'h00;
  localparam logic [6:0] SEL_HIGH = 7'h01;
  localparam logic [6:0] SEL_PATTERN = 7'h10;
  localparam logic [6:0] SEL_SLEEP = 7'h11;
  localparam logic [2:0] GRP_ACTIVE = 3'h2;
  localparam logic [2:0] GRP_LED = 3'h3;
  localparam logic [2:0] GRP_MOD = 3'h4;
  localparam logic [2:0] GRP_DATA = 3'h5;
  localparam logic [3:0] IDX_ANY = 4'hF;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SLOTS-1:0] slot_active;  // slot running
    logic [NUM_SLOTS-1:0] led_pulse;    // led pulse per slot
    logic [NUM_SLOTS-1:0] mod_pulse;    // modulation pulse per slot
    logic [NUM_SLOTS-1:0] data_cycle;   // output data cycle per slot
    logic [NUM_SLOTS-1:0] slot_pattern_level; // pattern level per slot
    logic sleep;                        // device asleep
  } gts_events_t;

  typedef struct packed {
    logic slot_pattern_idle_level;
    logic stamp_edge_invert;
    logic stamp_keep_armed;
    logic [1:0] stamp_pin_select;
  } gts_ext_t;

endpackage : gts_pkg

// file: verilog/gts_pin_block.sv
// general pin output select, input readback and time-stamp trigger logic
`timescale 1ns/1ps
// Operation
// - codes 0x37..0x3B drive the LED pulse of slots H..L
// - code 0x3F drives the OR of all slot LED pulses
// - codes 0x40..0x4B drive modulation pulse of slots A..L
// - code 0x4F drives the OR of all modulation pulses
// - codes 0x50..0x5B mark output data cycles of slots A..L
// - pin 0 select is 7 bits, same codes; bit above reads zero
// - input field reads levels of input-enabled pins; upper bits zero
// - code 0x10 returns to idle level after slot end and in sleep
// - edge invert clear: rising edge triggers; set: falling edge
// - keep-armed set: capture request not cleared after a capture
// - 2-bit stamp pin select; zero (reset) selects pin 0
// - stamp pin select one routes pin 1 to the trigger
// - code 0x10 drives per-slot level while slot runs, else idle
// - codes 0x00 and 0x01 drive constant low and high
module gts_pin_block #(
  parameter int unsigned NUM_SLOTS = gts_pkg::NUM_SLOTS
) (
  input wire logic clk,                          // 200 MHz clock
  input wire logic reset_n,                      // async reset, active low
  input wire logic [15:0] reg_addr,              // register address
  input wire logic reg_wr_en,                    // register write strobe
  input wire logic [15:0] reg_wr_data,           // register write data
  input wire logic reg_rd_en,                    // register read strobe
  output logic [15:0] reg_rd_data,               // read data, next cycle
  input wire gts_pkg::gts_events_t events,       // time-slot engine events
  input wire logic [1:0] pin_input_enable,       // pins enabled as inputs
  input wire logic [1:0] pin_output_enable,      // pins enabled as outputs
  input wire logic stamp_arm,                    // pulse: arm capture
  input wire logic [1:0] pin_in,                 // pin levels from pads
  output logic [1:0] pin_out,                    // pin drive levels
  output logic [1:0] pin_oe_n,                   // low while driving
  output logic stamp_capture_request,            // capture armed
  output logic stamp_trigger                     // pulse: take a stamp
);

  // ----------------------------------------------------------------------
  // output-select decode
  // ----------------------------------------------------------------------
  function automatic logic pick(input logic [NUM_SLOTS-1:0] vec,
                                input logic [3:0] idx);
    logic r;
    r = 1'b0;
    if (idx == gts_pkg::IDX_ANY) begin
      r = |vec;
    end else if (idx < 4'(NUM_SLOTS)) begin
      r = vec[idx];
    end
    return r;
  endfunction : pick

  function automatic logic decode(input logic [6:0] code,
                                  input gts_pkg::gts_events_t ev,
                                  input logic pattern);
    logic r;
    r = 1'b0;
    if (code == gts_pkg::SEL_HIGH) begin
      r = 1'b1;
    end else if (code == gts_pkg::SEL_PATTERN) begin
      r = pattern;
    end else if (code == gts_pkg::SEL_SLEEP) begin
      r = ev.sleep;
    end else begin
      case (code[6:4])
        gts_pkg::GRP_ACTIVE: begin
          r = (code[3:0] == gts_pkg::IDX_ANY) ? 1'b0
              : pick(ev.slot_active, code[3:0]);
        end
        gts_pkg::GRP_LED: r = pick(ev.led_pulse, code[3:0]);
        gts_pkg::GRP_MOD: r = pick(ev.mod_pulse, code[3:0]);
        gts_pkg::GRP_DATA: begin
          r = pick(ev.data_cycle, code[3:0]);
        end
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction : decode

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [6:0] pin0_output_select_reg;
  logic [6:0] pin0_output_select_next;
  logic [6:0] pin1_output_select_reg;
  logic [6:0] pin1_output_select_next;
  gts_pkg::gts_ext_t ext_reg;
  gts_pkg::gts_ext_t ext_next;
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;
  logic [1:0] pin_sync1_reg;
  logic [1:0] pin_sync2_reg;
  logic [1:0] input_levels;

  // register writes and read data
  always_comb begin
    pin0_output_select_next = pin0_output_select_reg;
    pin1_output_select_next = pin1_output_select_reg;
    ext_next = ext_reg;
    rd_data_next = rd_data_reg;
    if (reg_wr_en && reg_addr == gts_pkg::OFS_OUTPUT_SELECT) begin
      pin0_output_select_next =
        reg_wr_data[gts_pkg::POS_PIN0_SEL +: gts_pkg::SEL_W];
      pin1_output_select_next =
        reg_wr_data[gts_pkg::POS_PIN1_SEL +: gts_pkg::SEL_W];
    end
    if (reg_wr_en && reg_addr == gts_pkg::OFS_EXTENSION) begin
      ext_next.slot_pattern_idle_level = reg_wr_data[gts_pkg::POS_IDLE_LEVEL];
      ext_next.stamp_edge_invert = reg_wr_data[gts_pkg::POS_EDGE_INV];
      ext_next.stamp_keep_armed = reg_wr_data[gts_pkg::POS_KEEP_ARMED];
      ext_next.stamp_pin_select =
        reg_wr_data[gts_pkg::POS_PIN_SELECT +: 2];
    end
    if (reg_rd_en) begin
      case (reg_addr)
        gts_pkg::OFS_OUTPUT_SELECT: begin
          rd_data_next = {1'b0, pin1_output_select_reg,
                          1'b0, pin0_output_select_reg};
        end
        gts_pkg::OFS_INPUT_LEVELS: begin
          rd_data_next = {14'h0000, input_levels};
        end
        gts_pkg::OFS_EXTENSION: begin
          rd_data_next = {7'h00, ext_reg.slot_pattern_idle_level,
                          ext_reg.stamp_edge_invert,
                          ext_reg.stamp_keep_armed,
                          ext_reg.stamp_pin_select, 4'h0};
        end
        default: rd_data_next = 16'h0000;
      endcase
    end
  end

  // register update
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin0_output_select_reg <= gts_pkg::RST_SELECT;
      pin1_output_select_reg <= gts_pkg::RST_SELECT;
      ext_reg <= '0;
      rd_data_reg <= 16'h0000;
    end else begin
      pin0_output_select_reg <= pin0_output_select_next;
      pin1_output_select_reg <= pin1_output_select_next;
      ext_reg <= ext_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign reg_rd_data = rd_data_reg;

  // ----------------------------------------------------------------------
  // pin input synchroniser and readback
  // ----------------------------------------------------------------------
  // two flops before any logic sees a pad level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync1_reg <= 2'h0;
      pin_sync2_reg <= 2'h0;
    end else begin
      pin_sync1_reg <= pin_in;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  assign input_levels = pin_sync2_reg & pin_input_enable;

  // ----------------------------------------------------------------------
  // slot pattern and pin drive
  // ----------------------------------------------------------------------
  logic pattern_level;
  logic [1:0] pin_out_reg;
  logic [1:0] pin_out_next;
  logic [6:0] pin_sel [gts_pkg::NUM_PINS];

  // running slot's level, idle level between slots and in sleep
  always_comb begin
    if (events.sleep || ~|events.slot_active) begin
      pattern_level = ext_reg.slot_pattern_idle_level;
    end else begin
      pattern_level =
        |(events.slot_active & events.slot_pattern_level);
    end
  end

  assign pin_sel[0] = pin0_output_select_reg;
  assign pin_sel[1] = pin1_output_select_reg;

  // one decoder per pin
  genvar gp;
  generate
    for (gp = 0; gp < gts_pkg::NUM_PINS; gp++) begin : g_pin
      assign pin_out_next[gp] = decode(pin_sel[gp], events, pattern_level);
      assign pin_oe_n[gp] = ~pin_output_enable[gp];
    end
  endgenerate

  // drive levels come from flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_reg <= 2'h0;
    end else begin
      pin_out_reg <= pin_out_next;
    end
  end

  assign pin_out = pin_out_reg;

  // ----------------------------------------------------------------------
  // time-stamp trigger
  // ----------------------------------------------------------------------
  logic stamp_level;
  logic stamp_prev_reg;
  logic stamp_edge;
  logic request_reg;
  logic request_next;
  logic trigger_reg;
  logic trigger_next;

  // choose the trigger pin; codes 2 and 3 hold the trigger quiet
  always_comb begin
    case (ext_reg.stamp_pin_select)
      gts_pkg::STAMP_PIN0: stamp_level = pin_sync2_reg[0];
      gts_pkg::STAMP_PIN1: stamp_level = pin_sync2_reg[1];
      default: stamp_level = stamp_prev_reg;
    endcase
  end

  // rising edge, or falling edge when inverted
  assign stamp_edge = ext_reg.stamp_edge_invert
                    ? (stamp_prev_reg & ~stamp_level)
                    : (~stamp_prev_reg & stamp_level);

  // capture request: arm wins over the automatic clear
  always_comb begin
    trigger_next = request_reg & stamp_edge;
    request_next = request_reg;
    if (trigger_next && !ext_reg.stamp_keep_armed) begin
      request_next = 1'b0;
    end
    if (stamp_arm) begin
      request_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stamp_prev_reg <= 1'b0;
      request_reg <= 1'b0;
      trigger_reg <= 1'b0;
    end else begin
      stamp_prev_reg <= stamp_level;
      request_reg <= request_next;
      trigger_reg <= trigger_next;
    end
  end

  assign stamp_capture_request = request_reg;
  assign stamp_trigger = trigger_reg;

endmodule : gts_pin_block

// file: verification/gts_pin_block_properties.sv
// checker: output select, readback and stamp behaviour at the block ports
`timescale 1ns/1ps
module gts_pin_block_properties (
  input wire logic clk, // clock
  input wire logic reset_n, // async reset, active low
  input wire logic [15:0] reg_addr, // register address
  input wire logic reg_wr_en, // write strobe
  input wire logic [15:0] reg_wr_data, // write data
  input wire logic reg_rd_en, // read strobe
  input wire logic [15:0] reg_rd_data, // read data
  input wire gts_pkg::gts_events_t events, // slot events
  input wire logic stamp_arm, // arm pulse
  input wire logic [1:0] pin_out, // pin drive
  input wire logic stamp_capture_request, // armed level
  input wire logic stamp_trigger // stamp pulse
);
  logic [6:0] sel0_reg;
  logic [6:0] sel1_reg;
  logic [8:0] ext_reg;
  // shadow of the written control fields
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel0_reg <= 7'h00;
      sel1_reg <= 7'h00;
      ext_reg <= 9'h000;
    end else if (reg_wr_en && reg_addr == 16'h0023) begin
      sel0_reg <= reg_wr_data[6:0];
      sel1_reg <= reg_wr_data[14:8];
    end else if (reg_wr_en && reg_addr == 16'h0026) begin
      ext_reg <= reg_wr_data[8:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_const;
    sel0_reg[6:1] == 6'h00 |=> pin_out[0] == $past(sel0_reg[0]);
  endproperty
  a_const: assert property (p_const)
    else $error("constant drive wrong");
  property p_led;
    sel0_reg[6:4] == 3'h3 && sel0_reg[3:0] inside {[4'h7:4'hB]}
      |=> pin_out[0] == $past(events.led_pulse[sel0_reg[3:0]]);
  endproperty
  a_led: assert property (p_led)
    else $error("led pulse drive wrong");
  property p_mod;
    sel0_reg[6:4] == 3'h4 && sel0_reg[3:0] < 4'hC
      |=> pin_out[0] == $past(events.mod_pulse[sel0_reg[3:0]]);
  endproperty
  a_mod: assert property (p_mod)
    else $error("mod pulse drive wrong");
  property p_data;
    sel0_reg[6:4] == 3'h5 && sel0_reg[3:0] < 4'hC
      |=> pin_out[0] == $past(events.data_cycle[sel0_reg[3:0]]);
  endproperty
  a_data: assert property (p_data)
    else $error("data mark wrong");
  property p_pin1_any;
    sel1_reg == 7'h4F |=> pin_out[1] == $past(|events.mod_pulse);
  endproperty
  a_pin1_any: assert property (p_pin1_any)
    else $error("pin1 any wrong");
  property p_idle;
    sel0_reg == 7'h10 && (events.sleep || events.slot_active == 12'h000)
      |=> pin_out[0] == $past(ext_reg[8]);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle level wrong");
  property p_rdin;
    reg_rd_en && reg_addr == 16'h0025 |=> reg_rd_data[15:2] == 14'h0000;
  endproperty
  a_rdin: assert property (p_rdin)
    else $error("input upper bits set");
  // keep-armed as it stood in the cycle that produced the trigger
  property p_clear;
    stamp_trigger && !$past(stamp_arm)
      |-> stamp_capture_request == $past(ext_reg[6]);
  endproperty
  a_clear: assert property (p_clear)
    else $error("request clear wrong");
  property p_armed;
    $rose(stamp_trigger) |-> $past(stamp_capture_request);
  endproperty
  a_armed: assert property (p_armed)
    else $error("unarmed stamp");
  // main scenarios reached
  cover property (stamp_trigger && stamp_capture_request);
  cover property (sel0_reg == 7'h10 && events.sleep);
  cover property (sel1_reg == 7'h5F && pin_out[1]);
endmodule : gts_pin_block_properties
bind gts_pin_block gts_pin_block_properties u_props (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .events(events), .stamp_arm(stamp_arm),
  .pin_out(pin_out), .stamp_capture_request(stamp_capture_request),
  .stamp_trigger(stamp_trigger));

// file: verification/gts_ext_dev.sv
// partner: external device sharing the two general pins
`timescale 1ns/1ps
module gts_ext_dev (
  input wire logic [1:0] pin_out, // block drive level
  input wire logic [1:0] pin_oe_n, // low while block drives
  input wire logic [1:0] ext_level, // level this device drives
  output logic [1:0] pin_in // resolved pad level
);
  // the block wins where it drives, elsewhere this device sets the pad
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : gts_ext_dev

// file: verification/test_gts_pin_block.sv
// testbench: pin block output codes, readback and time stamp trigger
`timescale 1ns/1ps
module test_gts_pin_block;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wr_data = 16'h0000, reg_rd_data;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, stamp_arm = 1'b0;
  gts_pkg::gts_events_t events = '0;
  logic [1:0] pin_input_enable = 2'h3, pin_output_enable = 2'h0;
  logic [1:0] ext_level = 2'h0, pin_in, pin_out, pin_oe_n;
  logic stamp_capture_request, stamp_trigger;
  int errors = 0, total_checks = 0, cycles = 0;
  gts_pin_block DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .events(events),
    .pin_input_enable(pin_input_enable),
    .pin_output_enable(pin_output_enable),
    .stamp_arm(stamp_arm), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .stamp_capture_request(stamp_capture_request),
    .stamp_trigger(stamp_trigger));
  gts_ext_dev u_dev (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in));
  // clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1 check(reg_rd_data, exp);
  endtask : rd
  task automatic hold(input int p, input logic e);
    repeat (2) @(posedge clk);
    #1 check(16'(pin_out[p]), 16'(e));
  endtask : hold
  task automatic set_ev(input int f, input logic [11:0] v,
                        input logic [11:0] o);
    gts_pkg::gts_events_t e;
    e = '0;
    e.slot_active = (f == 3) ? v : o;
    e.sleep = (f == 4) ? v[0] : o[0];
    e.led_pulse = (f == 0) ? v : o;
    e.mod_pulse = (f == 1) ? v : o;
    e.data_cycle = (f == 2) ? v : o;
    @(posedge clk);
    events <= e;
  endtask : set_ev
  // one code: its own event raises the pin; the same slot of the other event fields (and, for one-slot codes, its field's other slots) leaves it low
  task automatic t_sel(input int p, input logic [6:0] c, input int f,
                       input int s, input logic any);
    logic [11:0] b;
    b = 12'h001 << s;
    wr(16'h0023, (p == 1) ? {1'b0, c, 8'h00} : {9'h000, c});
    set_ev(f, b, 12'h000);
    hold(p, 1'b1);
    set_ev(f, any ? 12'h000 : ~b, b);
    hold(p, 1'b0);
  endtask : t_sel
  task automatic t_pattern(input logic [11:0] act, input logic [11:0] lvl,
                           input logic e);
    gts_pkg::gts_events_t v;
    v = '0;
    v.slot_active = act;
    v.slot_pattern_level = lvl;
    @(posedge clk);
    events <= v;
    hold(0, e);
  endtask : t_pattern
  // pad change on the stamp pin, then count trigger pulses
  task automatic t_stamp(input logic [15:0] x, input logic arm,
                         input logic [1:0] v, input int n, input logic req);
    int k;
    k = 0;
    wr(16'h0026, x);
    @(posedge clk);
    stamp_arm <= arm;
    @(posedge clk);
    stamp_arm <= 1'b0;
    ext_level <= v;
    repeat (8) begin
      @(posedge clk);
      #1 if (stamp_trigger === 1'b1) k++;
    end
    check(16'(k), 16'(n));
    check(16'(stamp_capture_request), 16'(req));
  endtask : t_stamp
  // block drives pin 0 high; pad, enable and readback follow the drive
  task automatic t_drive();
    wr(16'h0023, 16'h0001);
    pin_output_enable <= 2'h1;
    repeat (6) @(posedge clk);
    #1 check(16'(pin_oe_n), 16'h0002);
    check(16'(pin_out), 16'h0001);
    rd(16'h0025, 16'h0001);
    @(posedge clk);
    pin_output_enable <= 2'h0;
  endtask : t_drive
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(16'h0023, 16'h0000);
    rd(16'h0026, 16'h0000);
    wr(16'h0023, 16'hFFFF);
    rd(16'h0023, 16'h7F7F);
    wr(16'h0026, 16'hFFFF);
    rd(16'h0026, 16'h01F0);
    rd(16'h0031, 16'h0000);
    wr(16'h0023, 16'h0100);
    hold(1, 1'b1);
    hold(0, 1'b0);
    for (int p = 0; p < 2; p++) begin
      for (int s = 7; s < 12; s++) begin
        t_sel(p, 7'h30 + 7'(s), 0, s, 0);
      end
      t_sel(p, 7'h3F, 0, 4, 1);
      for (int s = 0; s < 12; s++) begin
        t_sel(p, 7'h40 + 7'(s), 1, s, 0);
      end
      t_sel(p, 7'h4F, 1, 9, 1);
      for (int s = 0; s < 12; s++) begin
        t_sel(p, 7'h50 + 7'(s), 2, s, 0);
      end
      t_sel(p, 7'h5F, 2, 11, 1);
      t_sel(p, 7'h2B, 3, 11, 0);
      t_sel(p, 7'h11, 4, 0, 0);
    end
    wr(16'h0023, 16'h0010);
    t_pattern(12'h004, 12'h000, 1'b0);
    t_pattern(12'h004, 12'h004, 1'b1);
    t_pattern(12'h000, 12'h004, 1'b1);
    wr(16'h0026, 16'h0000);
    hold(0, 1'b0);
    @(posedge clk);
    ext_level <= 2'h2;
    repeat (6) @(posedge clk);
    rd(16'h0025, 16'h0002);
    @(posedge clk);
    pin_input_enable <= 2'h1;
    repeat (6) @(posedge clk);
    rd(16'h0025, 16'h0000);
    @(posedge clk);
    pin_input_enable <= 2'h3;
    ext_level <= 2'h0;
    t_drive();
    t_stamp(16'h0000, 1'b1, 2'h1, 1, 1'b0);
    t_stamp(16'h0010, 1'b1, 2'h0, 0, 1'b1);
    t_stamp(16'h0010, 1'b0, 2'h2, 1, 1'b0);
    t_stamp(16'h00C0, 1'b1, 2'h3, 0, 1'b1);
    t_stamp(16'h00C0, 1'b0, 2'h2, 1, 1'b1);
    t_stamp(16'h00C0, 1'b0, 2'h3, 0, 1'b1);
    t_stamp(16'h00C0, 1'b0, 2'h2, 1, 1'b1);
    print_verdict();
  end
endmodule : test_gts_pin_block
